/* File: hw/srap_top.sv */
// register access port: two-wire slave and serial-peripheral slave sharing one pointer
`timescale 1ns/1ns
module srap_top #(
    parameter logic [6:0] TW_ADDR  = srap_pkg::TW_ADDR_DEF,
    parameter logic [7:0] READ_CMD = srap_pkg::CMD_READ_DEF
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // configuration
    input  wire logic [1:0] i_mode,
    input  wire logic       i_deep_sleep_flag,
    // two-wire pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    // serial-peripheral pins
    input  wire logic       i_spi_cs_n,
    input  wire logic       i_spi_clk,
    input  wire logic       i_spi_mosi,
    output logic            o_spi_miso,
    output logic            o_spi_miso_oe,
    input  wire logic       i_shared_data_line,
    output logic            o_shared_data_line,
    output logic            o_shared_data_line_oe,
    // register file side
    output logic [7:0]      o_reg_addr,
    input  wire logic [7:0] i_reg_rdata,
    output logic            o_wr_en,
    output logic [7:0]      o_wr_addr,
    output logic [7:0]      o_wr_data
);

    typedef enum logic [3:0] {
        TW_IDLE, TW_ADDR_B, TW_AACK, TW_REG, TW_RACK,
        TW_WDAT, TW_WACK, TW_RDAT, TW_HACK, TW_RDLD
    } srap_tw_state_t;

    typedef enum logic [1:0] {SP_CMD, SP_ADDR, SP_WDAT, SP_RDAT} srap_sp_state_t;

    function automatic logic srap_known_cmd(input logic [7:0] b, input logic [7:0] rd);
        srap_known_cmd = (b == srap_pkg::CMD_RESET) || (b == srap_pkg::CMD_SET_PTR) ||
                         (b == srap_pkg::CMD_WRITE) || (b == rd);
    endfunction : srap_known_cmd

    logic [srap_pkg::PIN_W-1:0] pin_lvl;
    logic [srap_pkg::PIN_W-1:0] pin_rise;
    logic [srap_pkg::PIN_W-1:0] pin_fall;

    srap_pin_sync u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pins    ({i_shared_data_line, i_spi_mosi, i_spi_clk, i_spi_cs_n, i_sda, i_scl}),
        .o_lvl     (pin_lvl),
        .o_rise    (pin_rise),
        .o_fall    (pin_fall)
    );

    // shared pointer and register-side state
    logic [7:0]     ptr_r;
    logic [7:0]     obuf_r;
    logic           fetch_d_r;

    // two-wire engine state
    srap_tw_state_t tw_st_r;
    logic [3:0]     tw_bits_r;
    logic [7:0]     tw_sh_r;
    logic [7:0]     tw_tx_r;
    logic           tw_rw_r;
    logic           tw_got_reg_r;
    logic [7:0]     tw_pend_r;
    logic           tw_pend_v_r;
    logic           tw_rinc_r;
    logic           sda_oe_r;
    logic           tw_ld_r;
    logic [7:0]     tw_ldv_r;
    logic           tw_inc_r;
    logic           tw_wr_r;
    logic [7:0]     tw_wd_r;

    // serial-peripheral engine state, then the shared register write port
    srap_sp_state_t sp_st_r;
    logic [2:0]     sp_bits_r;
    logic [7:0]     sp_sh_r;
    logic           sp_prev7a_r;
    logic           sp_ld_r;
    logic [7:0]     sp_ldv_r;
    logic           sp_inc_r;
    logic           sp_wr_r;
    logic [7:0]     sp_wd_r;
    logic           sp_fetch_r;
    logic           sp_clr_r;
    logic           miso_r;
    logic           miso_oe_r;
    logic           msio_r;
    logic           msio_oe_r;
    logic           wr_en_r;
    logic [7:0]     wr_addr_r;
    logic [7:0]     wr_data_r;

    logic           tw_en;
    logic           sp_en;
    logic           three;
    logic           tw_start;
    logic           tw_stop;
    logic           tw_rise;
    logic           tw_fall;
    logic           tw_byte_end;
    logic           sp_act;
    logic           sp_din;
    logic [7:0]     sp_byte;
    logic           sp_done;
    logic           sp_rst_seq;

    assign tw_en  = (i_mode == srap_pkg::MODE_TWO_WIRE);
    assign three  = (i_mode == srap_pkg::MODE_THREE_WIRE);
    assign sp_en  = (i_mode == srap_pkg::MODE_FOUR_WIRE) || three;

    assign tw_start    = tw_en && pin_lvl[srap_pkg::PIN_SCL] && pin_fall[srap_pkg::PIN_SDA];
    assign tw_stop     = tw_en && pin_lvl[srap_pkg::PIN_SCL] && pin_rise[srap_pkg::PIN_SDA];
    assign tw_rise     = tw_en && pin_rise[srap_pkg::PIN_SCL];
    assign tw_fall     = tw_en && pin_fall[srap_pkg::PIN_SCL];
    assign tw_byte_end = tw_fall && (tw_bits_r == srap_pkg::TW_BYTE_BITS);

    assign sp_act     = sp_en && !pin_lvl[srap_pkg::PIN_CS_N];
    assign sp_din     = three ? pin_lvl[srap_pkg::PIN_MSIO] : pin_lvl[srap_pkg::PIN_MOSI];
    assign sp_byte    = {sp_sh_r[6:0], sp_din};
    assign sp_done    = sp_act && pin_rise[srap_pkg::PIN_SCLK] &&
                        (sp_bits_r == srap_pkg::SP_LAST_BIT);
    assign sp_rst_seq = sp_done && sp_prev7a_r && (sp_byte == srap_pkg::CMD_RESET);

    // two-wire slave; the line is open drain so only the enable moves
    always_ff @(posedge i_clk) begin
        tw_ld_r  <= 1'b0;
        tw_inc_r <= 1'b0;
        tw_wr_r  <= 1'b0;
        if (i_sys_rst || !tw_en) begin
            tw_st_r      <= TW_IDLE;
            tw_bits_r    <= 4'h0;
            tw_sh_r      <= 8'h00;
            tw_tx_r      <= 8'h00;
            tw_rw_r      <= 1'b0;
            tw_got_reg_r <= 1'b0;
            tw_pend_r    <= 8'h00;
            tw_pend_v_r  <= 1'b0;
            tw_rinc_r    <= 1'b0;
            sda_oe_r     <= 1'b0;
            tw_ldv_r     <= 8'h00;
            tw_wd_r      <= 8'h00;
        end else if (tw_start) begin
            tw_st_r   <= TW_ADDR_B;
            tw_bits_r <= 4'h0;
            sda_oe_r  <= 1'b0;
            // a repeated start makes a parked address real
            if (tw_pend_v_r) begin
                tw_ld_r     <= 1'b1;
                tw_ldv_r    <= tw_pend_r;
                tw_pend_v_r <= 1'b0;
            end
        end else if (tw_stop) begin
            // parked address dropped: send byte still sets the pointer in deep sleep, loaded in TW_WDAT at the clock rise before stop
            tw_st_r      <= TW_IDLE;
            sda_oe_r     <= 1'b0;
            tw_got_reg_r <= 1'b0;
            tw_pend_v_r  <= 1'b0;
        end else begin
            if (tw_rise) begin
                tw_bits_r <= tw_bits_r + 4'h1;
                tw_sh_r   <= {tw_sh_r[6:0], pin_lvl[srap_pkg::PIN_SDA]};
            end
            case (tw_st_r)
                TW_ADDR_B: begin
                    if (tw_byte_end) begin
                        // a bare read in deep sleep is a receive byte: not acked
                        if ((tw_sh_r[7:1] == TW_ADDR) &&
                            !(tw_sh_r[0] && i_deep_sleep_flag && !tw_got_reg_r)) begin
                            tw_rw_r  <= tw_sh_r[0];
                            sda_oe_r <= 1'b1;
                            tw_st_r  <= TW_AACK;
                        end else begin
                            tw_st_r  <= TW_IDLE;
                        end
                    end
                end
                TW_AACK: begin
                    if (tw_fall) begin
                        tw_bits_r <= 4'h0;
                        if (tw_rw_r) begin
                            tw_tx_r   <= i_reg_rdata;
                            sda_oe_r  <= ~i_reg_rdata[7];
                            tw_rinc_r <= tw_got_reg_r;
                            tw_st_r   <= TW_RDAT;
                        end else begin
                            sda_oe_r  <= 1'b0;
                            tw_st_r   <= TW_REG;
                        end
                    end
                end
                TW_REG: begin
                    if (tw_byte_end) begin
                        sda_oe_r     <= 1'b1;
                        tw_got_reg_r <= 1'b1;
                        tw_st_r      <= TW_RACK;
                        if (i_deep_sleep_flag) begin
                            tw_pend_r   <= tw_sh_r;
                            tw_pend_v_r <= 1'b1;
                        end else begin
                            tw_ld_r     <= 1'b1;
                            tw_ldv_r    <= tw_sh_r;
                        end
                    end
                end
                TW_RACK: begin
                    if (tw_fall) begin
                        sda_oe_r  <= 1'b0;
                        tw_bits_r <= 4'h0;
                        tw_st_r   <= TW_WDAT;
                    end
                end
                TW_WDAT: begin
                    if (tw_rise && tw_pend_v_r) begin
                        tw_ld_r     <= 1'b1;
                        tw_ldv_r    <= tw_pend_r;
                        tw_pend_v_r <= 1'b0;
                    end
                    if (tw_byte_end) begin
                        tw_wr_r  <= 1'b1;
                        tw_wd_r  <= tw_sh_r;
                        tw_inc_r <= 1'b1;
                        sda_oe_r <= 1'b1;
                        tw_st_r  <= TW_WACK;
                    end
                end
                TW_WACK: begin
                    if (tw_fall) begin
                        sda_oe_r  <= 1'b0;
                        tw_bits_r <= 4'h0;
                        tw_st_r   <= TW_WDAT;
                    end
                end
                TW_RDAT: begin
                    if (tw_byte_end) begin
                        sda_oe_r <= 1'b0;
                        tw_st_r  <= TW_HACK;
                    end else if (tw_fall) begin
                        sda_oe_r <= ~tw_tx_r[3'h7 - tw_bits_r[2:0]];
                    end
                end
                TW_HACK: begin
                    if (tw_rise) begin
                        if (!pin_lvl[srap_pkg::PIN_SDA]) begin
                            tw_inc_r <= tw_rinc_r;
                            tw_st_r  <= TW_RDLD;
                        end else begin
                            tw_st_r  <= TW_IDLE;
                        end
                    end
                end
                TW_RDLD: begin
                    if (tw_fall) begin
                        tw_tx_r   <= i_reg_rdata;
                        sda_oe_r  <= ~i_reg_rdata[7];
                        tw_bits_r <= 4'h0;
                        tw_st_r   <= TW_RDAT;
                    end
                end
                default: tw_st_r <= TW_IDLE;
            endcase
        end
    end

    // serial-peripheral slave; no timeout, a stall waits for clocks or chip select
    always_ff @(posedge i_clk) begin
        sp_ld_r    <= 1'b0;
        sp_inc_r   <= 1'b0;
        sp_wr_r    <= 1'b0;
        sp_fetch_r <= 1'b0;
        sp_clr_r   <= 1'b0;
        if (i_sys_rst || !sp_act) begin
            sp_st_r     <= SP_CMD;
            sp_bits_r   <= 3'h0;
            sp_sh_r     <= 8'h00;
            sp_prev7a_r <= 1'b0;
            sp_ldv_r    <= 8'h00;
            sp_wd_r     <= 8'h00;
        end else if (pin_rise[srap_pkg::PIN_SCLK]) begin
            sp_bits_r <= sp_bits_r + 3'h1;
            sp_sh_r   <= sp_byte;
            if (sp_done) begin
                if (sp_rst_seq) begin
                    sp_st_r     <= SP_CMD;
                    sp_clr_r    <= 1'b1;
                    sp_prev7a_r <= 1'b0;
                end else begin
                    sp_prev7a_r <= (sp_byte == srap_pkg::CMD_RESET);
                    case (sp_st_r)
                        SP_CMD: begin
                            if (sp_byte == srap_pkg::CMD_SET_PTR) begin
                                sp_st_r    <= SP_ADDR;
                            end else if (sp_byte == srap_pkg::CMD_WRITE) begin
                                sp_st_r    <= SP_WDAT;
                                sp_fetch_r <= 1'b1;
                            end else if (sp_byte == READ_CMD) begin
                                sp_st_r    <= SP_RDAT;
                                sp_fetch_r <= 1'b1;
                            end
                        end
                        SP_ADDR: begin
                            sp_ld_r    <= 1'b1;
                            sp_ldv_r   <= sp_byte;
                            sp_fetch_r <= 1'b1;
                            sp_st_r    <= SP_CMD;
                        end
                        SP_WDAT: begin
                            sp_wr_r    <= 1'b1;
                            sp_wd_r    <= sp_byte;
                            sp_inc_r   <= 1'b1;
                            sp_fetch_r <= 1'b1;
                            // four-wire keeps taking data bytes, three-wire takes one
                            sp_st_r    <= three ? SP_CMD : SP_WDAT;
                        end
                        SP_RDAT: begin
                            sp_inc_r   <= 1'b1;
                            sp_fetch_r <= 1'b1;
                            sp_st_r    <= three ? SP_CMD : SP_RDAT;
                        end
                        default: sp_st_r <= SP_CMD;
                    endcase
                end
            end
        end
    end

    // single pointer; engines are exclusive by mode so requests never collide
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ptr_r <= srap_pkg::PTR_RESET;
        end else if (tw_ld_r) begin
            ptr_r <= tw_ldv_r;
        end else if (sp_ld_r) begin
            ptr_r <= sp_ldv_r;
        end else if (tw_inc_r || sp_inc_r) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // register write port captures the pointer before its increment lands
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_en_r   <= 1'b0;
            wr_addr_r <= srap_pkg::PTR_RESET;
            wr_data_r <= 8'h00;
        end else begin
            wr_en_r <= tw_wr_r || sp_wr_r;
            if (tw_wr_r || sp_wr_r) begin
                wr_addr_r <= ptr_r;
                wr_data_r <= tw_wr_r ? tw_wd_r : sp_wd_r;
            end
        end
    end

    // output buffer fetch waits one cycle so the new pointer has reached read data
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fetch_d_r <= 1'b0;
            obuf_r    <= srap_pkg::OBUF_RESET;
        end else begin
            fetch_d_r <= sp_fetch_r;
            if (sp_clr_r) begin
                obuf_r <= srap_pkg::OBUF_RESET;
            end else if (fetch_d_r) begin
                obuf_r <= i_reg_rdata;
            end
        end
    end

    // serial-peripheral data pins, idle high when released
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            miso_r    <= 1'b1;
            miso_oe_r <= 1'b0;
            msio_r    <= 1'b1;
            msio_oe_r <= 1'b0;
        end else begin
            miso_oe_r <= sp_act && !three;
            miso_r    <= sp_act ? obuf_r[3'h7 - sp_bits_r] : 1'b1;
            msio_oe_r <= sp_act && three && (sp_st_r == SP_RDAT);
            msio_r    <= sp_act ? obuf_r[3'h7 - sp_bits_r] : 1'b1;
        end
    end

    assign o_sda                 = 1'b0;
    assign o_sda_oe              = sda_oe_r;
    assign o_spi_miso            = miso_r;
    assign o_spi_miso_oe         = miso_oe_r;
    assign o_shared_data_line    = msio_r;
    assign o_shared_data_line_oe = msio_oe_r;
    assign o_reg_addr            = ptr_r;
    assign o_wr_en               = wr_en_r;
    assign o_wr_addr             = wr_addr_r;
    assign o_wr_data             = wr_data_r;

    a_spi_ptr_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (sp_done && !sp_rst_seq && (sp_st_r == SP_RDAT) && (ptr_r == srap_pkg::PTR_LAST))
        |=> ##1 (ptr_r == srap_pkg::PTR_RESET))
        else $error("pointer did not wrap after read byte");

    a_reset_clears_buf: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        sp_rst_seq |=> ##1 ((obuf_r == srap_pkg::OBUF_RESET) && (sp_st_r == SP_CMD)))
        else $error("reset sequence did not clear buffer");

    a_unknown_cmd_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (sp_done && !sp_rst_seq && (sp_st_r == SP_CMD) && !srap_known_cmd(sp_byte, READ_CMD))
        |=> ((sp_st_r == SP_CMD) && !sp_ld_r && !sp_inc_r && !sp_wr_r && !sp_fetch_r)
        ##1 $stable(ptr_r))
        else $error("unknown command changed state");

    a_setptr_fetch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (sp_done && !sp_rst_seq && (sp_st_r == SP_ADDR))
        |=> ##1 (ptr_r == $past(sp_byte, 2)) ##1 (obuf_r == $past(i_reg_rdata)))
        else $error("set pointer did not load and fetch");

    a_write_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (sp_done && !sp_rst_seq && (sp_st_r == SP_WDAT))
        |=> ##1 (o_wr_en && (o_wr_data == $past(sp_byte, 2)) && (o_wr_addr == $past(ptr_r, 2))))
        else $error("write byte not stored at pointer");

    a_cs_high_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        pin_lvl[srap_pkg::PIN_CS_N] |=> (!o_spi_miso_oe && !o_shared_data_line_oe))
        else $error("data driven with chip select high");

    a_msio_turnaround: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_shared_data_line_oe |-> ($past(three) && $past(sp_st_r == SP_RDAT)))
        else $error("shared line driven outside read data");

    a_mode_gates_tw: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_mode != srap_pkg::MODE_TWO_WIRE) |=> (!o_sda_oe && (tw_st_r == TW_IDLE)))
        else $error("two-wire engine active in other mode");

    a_tw_write_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (tw_en && !tw_start && !tw_stop && (tw_st_r == TW_WDAT) && tw_byte_end &&
         (ptr_r == srap_pkg::PTR_LAST))
        |=> ##1 (o_wr_en && (o_wr_addr == srap_pkg::PTR_LAST) && (ptr_r == srap_pkg::PTR_RESET)))
        else $error("block write did not store and wrap");

endmodule : srap_top

/* File: hw/srap_pkg.sv */
// shared constants for the serial register access port
package srap_pkg;

    // interface selection codes
    localparam logic [1:0] MODE_TWO_WIRE   = 2'h0;
    localparam logic [1:0] MODE_FOUR_WIRE  = 2'h1;
    localparam logic [1:0] MODE_THREE_WIRE = 2'h2;

    // serial-peripheral command codes
    localparam logic [7:0] CMD_RESET    = 8'h7A;
    localparam logic [7:0] CMD_SET_PTR  = 8'h7D;
    localparam logic [7:0] CMD_WRITE    = 8'h7E;
    // read opcode default is arbitrary; override at the top level
    localparam logic [7:0] CMD_READ_DEF = 8'h7F;

    // two-wire device address default is arbitrary
    localparam logic [6:0] TW_ADDR_DEF  = 7'h2C;

    // pointer and output buffer values
    localparam logic [7:0] PTR_RESET    = 8'h00;
    localparam logic [7:0] PTR_LAST     = 8'hFF;
    localparam logic [7:0] OBUF_RESET   = 8'h00;

    // bit count and last bit index per byte
    localparam logic [3:0] TW_BYTE_BITS = 4'h8;
    localparam logic [2:0] SP_LAST_BIT  = 3'h7;

    // synchronised pin bundle layout, all pins idle high
    localparam int         PIN_W        = 6;
    localparam logic [5:0] PIN_IDLE     = 6'h3F;
    localparam int         PIN_SCL      = 0;
    localparam int         PIN_SDA      = 1;
    localparam int         PIN_CS_N     = 2;
    localparam int         PIN_SCLK     = 3;
    localparam int         PIN_MOSI     = 4;
    localparam int         PIN_MSIO     = 5;

endpackage : srap_pkg

/* File: hw/srap_pin_sync.sv */
// two-flop pin synchroniser with edge detection
`timescale 1ns/1ns
module srap_pin_sync (
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_sys_rst,
    // raw pins
    input  wire logic [srap_pkg::PIN_W-1:0] i_pins,
    // synchronised level and edge pulses
    output logic      [srap_pkg::PIN_W-1:0] o_lvl,
    output logic      [srap_pkg::PIN_W-1:0] o_rise,
    output logic      [srap_pkg::PIN_W-1:0] o_fall
);

    logic [srap_pkg::PIN_W-1:0] meta_r;
    logic [srap_pkg::PIN_W-1:0] sync_r;
    logic [srap_pkg::PIN_W-1:0] prev_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_r <= srap_pkg::PIN_IDLE;
            sync_r <= srap_pkg::PIN_IDLE;
            prev_r <= srap_pkg::PIN_IDLE;
        end else begin
            meta_r <= i_pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_lvl  = sync_r;
    assign o_rise = sync_r & ~prev_r;
    assign o_fall = ~sync_r & prev_r;

endmodule : srap_pin_sync

/* File: testbench/srap_host_model.sv */
// host controller model driving the serial-peripheral and two-wire pins
`timescale 1ns/1ns
module srap_host_model (
    input  wire logic i_clk,
    input  wire logic i_miso,
    input  wire logic i_sda,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi,
    output logic      o_scl,
    output logic      o_sda
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_mosi = 1'b1;
        o_scl  = 1'b1;
        o_sda  = 1'b1;
    end
    task automatic sel(input logic v);
        repeat (4) @(posedge i_clk);
        o_cs_n <= v;
        o_mosi <= 1'b1;
    endtask : sel
    // msb first; miso read at each rise, before the device moves to the next bit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
            o_mosi <= tx[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            rx[i] = i_miso;
        end
    endtask : xfer
    // two-wire start (1) or stop (0); the data line changes while the clock is high
    task automatic tw_cond(input logic start);
        repeat (4) @(posedge i_clk);
        o_sda <= start;
        repeat (4) @(posedge i_clk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_sda <= !start;
        repeat (4) @(posedge i_clk);
        o_scl <= !start;
    endtask : tw_cond
    // one bit: drive in the low phase, read the wire late in the high phase
    task automatic tw_bit(input logic b, output logic r);
        repeat (4) @(posedge i_clk);
        o_sda <= b;
        repeat (4) @(posedge i_clk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_clk);
        r = i_sda;
        o_scl <= 1'b0;
    endtask : tw_bit
    // eight bits msb first, then the ninth slot: host drives ha, the wire gives ack
    task automatic tw_byte(input logic [7:0] tx, input logic ha, output logic [7:0] rx,
        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            tw_bit(tx[i], b);
            rx[i] = b;
        end
        tw_bit(ha, ack);
    endtask : tw_byte
endmodule : srap_host_model

/* File: testbench/srap_top_tb_top.sv */
// self-checking bench for the register access port in all three link modes
`timescale 1ns/1ns
module srap_top_tb_top;
    localparam logic [7:0] RD = 8'h7F;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] mode = srap_pkg::MODE_FOUR_WIRE;
    logic       deep_sleep = 1'b0;
    logic       cs_n, sclk, mosi, miso, miso_oe, shd, shd_oe, scl, h_sda, sda_q, sda_oe, wr_en;
    logic [7:0] reg_addr, wr_addr, wr_data;
    logic [7:0] regs [256];
    int         n_mismatch = 0;
    int         checks_done = 0;
    // released lines read high; the shared line follows whichever side drives it
    wire        shd_line = shd_oe ? shd : mosi;
    wire        so       = (mode == srap_pkg::MODE_THREE_WIRE) ? shd_line :
                           (miso_oe ? miso : 1'b1);
    wire        sda      = sda_oe ? sda_q : h_sda;
    always #20 clk = ~clk;
    // register file stand-in, read combinationally as the port expects
    always @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) regs[i] <= i[7:0] ^ 8'hC3;
        end else if (wr_en) begin
            regs[wr_addr] <= wr_data;
        end
    end
    srap_host_model host (.i_clk(clk), .i_miso(so), .i_sda(sda), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_mosi(mosi), .o_scl(scl), .o_sda(h_sda));
    srap_top #(.READ_CMD(RD)) dut (.i_clk(clk), .i_sys_rst(rst), .i_mode(mode),
        .i_deep_sleep_flag(deep_sleep), .i_scl(scl), .i_sda(sda), .o_sda(sda_q),
        .o_sda_oe(sda_oe), .i_spi_cs_n(cs_n), .i_spi_clk(sclk), .i_spi_mosi(mosi),
        .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_shared_data_line(shd_line),
        .o_shared_data_line(shd), .o_shared_data_line_oe(shd_oe), .o_reg_addr(reg_addr),
        .i_reg_rdata(regs[reg_addr]), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
        .o_wr_data(wr_data));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    // pointer at the top address, two data bytes: write wraps to zero
    task automatic t_write();
        logic [7:0] r;
        host.sel(1'b0);
        host.xfer(8'h7D, r);
        host.xfer(8'hFF, r);
        host.xfer(8'h7E, r);
        host.xfer(8'hA5, r);
        chk(r, 8'h3C);
        host.xfer(8'h5A, r);
        chk(r, 8'hC3);
        host.sel(1'b1);
        repeat (8) @(posedge clk);
        chk(regs[8'hFF], 8'hA5);
        chk(regs[8'h00], 8'h5A);
        chk(reg_addr, 8'h01);
    endtask : t_write
    // two commands in one select period, then a streamed read
    task automatic t_read();
        logic [7:0] r;
        host.sel(1'b0);
        host.xfer(8'h7D, r);
        host.xfer(8'h10, r);
        host.xfer(RD, r);
        host.xfer(8'h00, r);
        chk(r, 8'hD3);
        host.xfer(8'h00, r);
        chk(r, 8'hD2);
        host.sel(1'b1);
        repeat (8) @(posedge clk);
        chk(reg_addr, 8'h12);
    endtask : t_read
    // buffer fetched by set-pointer, cleared by the double reset code
    task automatic t_reset();
        logic [7:0] r;
        logic [7:0] p;
        host.sel(1'b0);
        host.xfer(8'h7D, r);
        host.xfer(8'h20, r);
        repeat (6) @(posedge clk);
        chk(reg_addr, 8'h20);
        host.xfer(8'h7A, r);
        chk(r, 8'hE3);
        host.xfer(8'h7A, r);
        host.xfer(8'h55, r);
        chk(r, 8'h00);
        p = reg_addr;
        host.xfer(8'h55, r);
        chk(r, 8'h00);
        repeat (8) @(posedge clk);
        chk(reg_addr, p);
        host.sel(1'b1);
    endtask : t_reset
    // three-wire: read wraps the pointer, one-byte write, then a read of the next register
    task automatic t_three();
        logic [7:0] r;
        repeat (4) @(posedge clk);
        mode <= srap_pkg::MODE_THREE_WIRE;
        host.sel(1'b0);
        host.xfer(8'h7D, r);
        host.xfer(8'hFF, r);
        host.xfer(RD, r);
        host.xfer(8'hFF, r);
        chk(r, 8'hA5);
        host.xfer(8'h7E, r);
        host.xfer(8'h66, r);
        host.xfer(RD, r);
        host.xfer(8'hFF, r);
        chk(r, 8'hC2);
        host.sel(1'b1);
        repeat (8) @(posedge clk);
        chk(regs[8'h00], 8'h66);
        chk(reg_addr, 8'h02);
    endtask : t_three
    // two-wire: block write across the top address, receive byte, block read across it,
    // then a bare read refused in deep sleep
    task automatic t_two();
        logic [7:0] r;
        logic       a;
        repeat (4) @(posedge clk);
        mode <= srap_pkg::MODE_TWO_WIRE;
        host.tw_cond(1'b1);
        host.tw_byte({srap_pkg::TW_ADDR_DEF, 1'b0}, 1'b1, r, a);
        chk({7'h00, a}, 8'h00);
        host.tw_byte(8'hFF, 1'b1, r, a);
        host.tw_byte(8'h11, 1'b1, r, a);
        host.tw_byte(8'h22, 1'b1, r, a);
        chk({7'h00, a}, 8'h00);
        host.tw_cond(1'b0);
        repeat (8) @(posedge clk);
        chk(regs[8'hFF], 8'h11);
        chk(regs[8'h00], 8'h22);
        chk(reg_addr, 8'h01);
        host.tw_cond(1'b1);
        host.tw_byte({srap_pkg::TW_ADDR_DEF, 1'b1}, 1'b1, r, a);
        host.tw_byte(8'hFF, 1'b1, r, a);
        chk(r, 8'hC2);
        host.tw_cond(1'b0);
        repeat (8) @(posedge clk);
        chk(reg_addr, 8'h01);
        host.tw_cond(1'b1);
        host.tw_byte({srap_pkg::TW_ADDR_DEF, 1'b0}, 1'b1, r, a);
        host.tw_byte(8'hFF, 1'b1, r, a);
        chk(reg_addr, 8'hFF);
        host.tw_cond(1'b1);
        host.tw_byte({srap_pkg::TW_ADDR_DEF, 1'b1}, 1'b1, r, a);
        host.tw_byte(8'hFF, 1'b0, r, a);
        chk(r, 8'h11);
        host.tw_byte(8'hFF, 1'b1, r, a);
        chk(r, 8'h22);
        host.tw_cond(1'b0);
        repeat (8) @(posedge clk);
        chk(reg_addr, 8'h00);
        deep_sleep <= 1'b1;
        host.tw_cond(1'b1);
        host.tw_byte({srap_pkg::TW_ADDR_DEF, 1'b1}, 1'b1, r, a);
        chk({7'h00, a}, 8'h01);
        host.tw_cond(1'b0);
    endtask : t_two
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_write();
        t_read();
        t_reset();
        t_three();
        t_two();
        results();
    end
    // whole run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule : srap_top_tb_top
